//--- shared/stb_pkg.sv
// Package for the serial transmit/break block: register map, fields, resets.
// Assumes a 32-bit AXI4-Lite slave and one 100 MHz clock.
package stb_pkg;
  localparam int unsigned STB_CLK_HZ = 100000000;
  localparam logic [7:0] STB_OFS_CTRL1 = 8'h00;
  localparam logic [7:0] STB_OFS_CTRL2 = 8'h04;
  localparam logic [7:0] STB_OFS_BAUD = 8'h08;
  localparam logic [7:0] STB_OFS_STAT = 8'h0C;
  localparam logic [7:0] STB_OFS_DATA = 8'h10;
  localparam logic [7:0] STB_OFS_MASK = 8'h14;
  // Control one fields
  localparam int STB_C1_LONG = 0;
  localparam int STB_C1_PAR_EN = 1;
  localparam int STB_C1_PAR_ODD = 2;
  localparam int STB_C1_BRK_DET_EN = 3;
  // Control two fields
  localparam int STB_C2_RX_EN = 0;
  localparam int STB_C2_TX_EN = 1;
  localparam int STB_C2_SEND_BRK = 2;
  // Status fields
  localparam int STB_ST_TX_EMPTY = 0;
  localparam int STB_ST_TX_DONE = 1;
  localparam int STB_ST_RX_FULL = 2;
  localparam int STB_ST_OVERRUN = 3;
  localparam int STB_ST_NOISE = 4;
  localparam int STB_ST_FRAME_ERR = 5;
  localparam int STB_ST_PAR_ERR = 6;
  localparam int STB_ST_BRK_IRQ = 7;
  localparam int STB_ST_RX_ACTIVE = 8;
  localparam int STB_ST_W = 9;
  localparam logic [15:0] STB_BAUD_RST = 16'h0010;
  localparam logic [15:0] STB_BAUD_MIN = 16'h0002;
  localparam logic [3:0] STB_BRK_BITS_SHORT = 4'hA;
  localparam logic [3:0] STB_BRK_BITS_LONG = 4'hB;
  localparam logic [1:0] STB_AXI_OKAY = 2'h0;
  localparam logic [1:0] STB_AXI_SLVERR = 2'h2;
endpackage

//--- shared/stb_rx_if.sv
// Bundle between the top and the receiver: settings in, events and data out.
// Assumes one clock domain.
`timescale 1ns/1ps
interface stb_rx_if;
  logic enable;
  logic long_char;
  logic par_en;
  logic par_odd;
  logic brk_det_en;
  logic [15:0] bit_div;
  logic rx_done;
  logic [8:0] rx_data;
  logic frame_err;
  logic par_err;
  logic noise;
  logic brk_seen;
  logic active;
  modport top (output enable, long_char, par_en, par_odd, brk_det_en, bit_div,
    input rx_done, rx_data, frame_err, par_err, noise, brk_seen, active);
  modport rx (input enable, long_char, par_en, par_odd, brk_det_en, bit_div,
    output rx_done, rx_data, frame_err, par_err, noise, brk_seen, active);
endinterface

//--- rtl/stb_rx.sv
// Receiver: samples the line at mid-bit, frames characters and spots breaks.
// Assumes RXD already passed two flip-flops in the top.
`timescale 1ns/1ps
module stb_rx
(
  input wire logic clk,
  input wire logic rst,
  input wire logic rxd,
  stb_rx_if.rx rif
);
  import stb_pkg::*;
  typedef enum logic [1:0] {ST_IDLE, ST_BITS, ST_HOLD} stb_rx_state_t;
  stb_rx_state_t state_r;
  logic [15:0] div_r;
  logic [3:0] bit_r;
  logic [8:0] shf_r;
  logic [3:0] zero_r;
  logic par_r;
  logic [2:0] smp_r;
  logic [3:0] nbits;
  logic [15:0] half;
  logic [3:0] brk_len;
  logic tick;
  logic maj;

  assign nbits = brk_len - 4'h1;
  assign brk_len = rif.long_char ? STB_BRK_BITS_LONG : STB_BRK_BITS_SHORT;
  assign half = {1'b0, rif.bit_div[15:1]};
  assign tick = (div_r == 16'h0000);
  assign maj = (smp_r[0] & smp_r[1]) | (smp_r[1] & smp_r[2]) | (smp_r[0] & smp_r[2]);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      smp_r <= 3'h7;
    else
      smp_r <= {smp_r[1:0], rxd};
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      div_r <= 16'h0000;
      bit_r <= 4'h0;
      shf_r <= 9'h000;
      par_r <= 1'b0;
    end
    else if (!rif.enable)
      state_r <= ST_IDLE;
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (!smp_r[2])
          begin
            state_r <= ST_BITS;
            div_r <= half;
            bit_r <= 4'h0;
            par_r <= 1'b0;
          end
        end
        ST_BITS:
        begin
          if (!tick)
            div_r <= div_r - 16'h0001;
          else
          begin
            div_r <= rif.bit_div - 16'h0001;
            bit_r <= bit_r + 4'h1;
            if (bit_r == 4'h0 && maj)
              state_r <= ST_IDLE;
            else if (bit_r == nbits)
              state_r <= maj ? ST_IDLE : ST_HOLD;
            else if (bit_r != 4'h0)
            begin
              shf_r <= {maj, shf_r[8:1]};
              par_r <= par_r ^ maj;
            end
          end
        end
        // Low stop bit: keep bit timing until the line rises, so a long
        // low run counts as one break instead of restarting a frame
        ST_HOLD:
        begin
          if (smp_r[2])
            state_r <= ST_IDLE;
          else if (!tick)
            div_r <= div_r - 16'h0001;
          else
            div_r <= rif.bit_div - 16'h0001;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Zero-run counter on sampled bit times, framing or holding; saturates
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      zero_r <= 4'h0;
    else if (smp_r[2])
      zero_r <= 4'h0;
    else if (state_r != ST_IDLE && tick && zero_r != 4'hF)
      zero_r <= zero_r + 4'h1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rif.rx_done <= 1'b0;
      rif.rx_data <= 9'h000;
      rif.frame_err <= 1'b0;
      rif.par_err <= 1'b0;
      rif.noise <= 1'b0;
      rif.brk_seen <= 1'b0;
      rif.active <= 1'b0;
    end
    else
    begin
      rif.active <= (state_r == ST_BITS);
      rif.noise <= tick && (state_r == ST_BITS) && (smp_r[0] != smp_r[2]);
      rif.rx_done <= 1'b0;
      rif.brk_seen <= 1'b0;
      if (state_r == ST_BITS && tick && bit_r == nbits)
      begin
        // A high stop bit after nine zeros (ten in long mode) is a zero byte, not a break
        if (zero_r >= brk_len - 4'h1 && !maj && rif.brk_det_en)
          rif.brk_seen <= 1'b1;
        else
        begin
          rif.rx_done <= 1'b1;
          rif.rx_data <= rif.long_char ? shf_r : {1'b0, shf_r[8:1]};
          rif.frame_err <= !maj;
          rif.par_err <= rif.par_en && (par_r ^ rif.par_odd);
        end
      end
      else if (state_r == ST_HOLD && tick && !smp_r[2]
               && zero_r == brk_len - 4'h1 && rif.brk_det_en)
        rif.brk_seen <= 1'b1;
    end
  end
endmodule

//--- rtl/stb_top.sv
// Serial transmitter with break and preamble generation plus break-aware receiver.
// Assumes an AXI4-Lite master on CLK and a remote transceiver on TXD/RXD.
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module stb_top
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic RXD,
  output logic TXD,
  output logic IRQ
);
  import stb_pkg::*;
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} stb_tx_state_t;
  typedef enum logic [1:0] {LD_DATA, LD_BREAK, LD_PREAMBLE} stb_load_t;

  stb_rx_if rif ();
  logic [3:0] ctrl1_r;
  logic [2:0] ctrl2_r;
  logic [15:0] baud_r;
  logic [8:0] tdr_r;
  logic [8:0] rdr_r;
  logic [STB_ST_W-1:0] stat_r;
  logic [STB_ST_W-1:0] mask_r;
  logic [1:0] rx_sync_r;
  logic aw_got_r, w_got_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  stb_tx_state_t tx_state_r;
  stb_load_t load_kind_r;
  logic [11:0] tx_shf_r;
  logic [3:0] tx_cnt_r;
  logic [15:0] tx_div_r;
  logic preamble_pend_r;
  logic brk_tail_r;
  logic tx_empty_r;
  logic tx_en_prev_r;
  logic wr_fire, rd_fire, data_wr, stat_rd, data_rd, load_now;
  logic [3:0] char_bits;
  logic [11:0] frame_word;
  logic [STB_ST_W-1:0] stat_set;
  logic [31:0] rd_val;

  assign wr_fire = aw_got_r && w_got_r && !BVALID;
  assign rd_fire = ARVALID && ARREADY;
  assign data_wr = wr_fire && aw_addr_r == STB_OFS_DATA && w_strb_r[0];
  assign stat_rd = rd_fire && ARADDR == STB_OFS_STAT;
  assign data_rd = rd_fire && ARADDR == STB_OFS_DATA;
  assign char_bits = ctrl1_r[STB_C1_LONG] ? STB_BRK_BITS_LONG : STB_BRK_BITS_SHORT;

  // Frame LSB first: start, data, optional parity, stop
  always_comb
  begin
    frame_word = 12'hFFF;
    if (ctrl1_r[STB_C1_LONG])
      frame_word = {2'b11, tdr_r[8] ^ 1'b0, tdr_r[7:0], 1'b0};
    else
      frame_word = {3'b111, tdr_r[7:0], 1'b0};
    if (ctrl1_r[STB_C1_PAR_EN])
    begin
      if (ctrl1_r[STB_C1_LONG])
        frame_word[9] = ^tdr_r[7:0] ^ ctrl1_r[STB_C1_PAR_ODD];
      else
        frame_word[8] = ^tdr_r[6:0] ^ ctrl1_r[STB_C1_PAR_ODD];
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      rx_sync_r <= 2'b11;
    else
      rx_sync_r <= {rx_sync_r[0], RXD};
  end

  // AXI write channel: address and data taken in either order
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      BVALID <= 1'b0;
      BRESP <= STB_AXI_OKAY;
    end
    else
    begin
      if (AWVALID && AWREADY)
      begin
        aw_got_r <= 1'b1;
        aw_addr_r <= AWADDR;
        AWREADY <= 1'b0;
      end
      if (WVALID && WREADY)
      begin
        w_got_r <= 1'b1;
        w_data_r <= WDATA;
        w_strb_r <= WSTRB;
        WREADY <= 1'b0;
      end
      if (wr_fire)
      begin
        BVALID <= 1'b1;
        BRESP <= (aw_addr_r > STB_OFS_MASK || aw_addr_r[1:0] != 2'b00
                  || aw_addr_r == STB_OFS_STAT) ? STB_AXI_SLVERR : STB_AXI_OKAY;
      end
      if (BVALID && BREADY)
      begin
        BVALID <= 1'b0;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ctrl1_r <= 4'h0;
      ctrl2_r <= 3'h0;
      baud_r <= STB_BAUD_RST;
      mask_r <= '0;
      tdr_r <= 9'h000;
    end
    else if (wr_fire && w_strb_r[0])
    begin
      case (aw_addr_r)
        STB_OFS_CTRL1: ctrl1_r <= w_data_r[3:0];
        STB_OFS_CTRL2: ctrl2_r <= w_data_r[2:0];
        STB_OFS_BAUD:
          baud_r <= (w_data_r[15:0] < STB_BAUD_MIN) ? STB_BAUD_MIN : w_data_r[15:0];
        STB_OFS_MASK: mask_r <= w_data_r[STB_ST_W-1:0];
        STB_OFS_DATA: tdr_r <= w_data_r[8:0];
        default: ;
      endcase
    end
  end

  always_comb
  begin
    rd_val = 32'h0000_0000;
    case (ARADDR)
      STB_OFS_CTRL1: rd_val = {28'h0, ctrl1_r};
      STB_OFS_CTRL2: rd_val = {29'h0, ctrl2_r};
      STB_OFS_BAUD: rd_val = {16'h0, baud_r};
      STB_OFS_STAT: rd_val = {23'h0, stat_r};
      STB_OFS_DATA: rd_val = {23'h0, rdr_r};
      STB_OFS_MASK: rd_val = {23'h0, mask_r};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= STB_AXI_OKAY;
    end
    else if (rd_fire)
    begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RDATA <= rd_val;
      RRESP <= (ARADDR > STB_OFS_MASK || ARADDR[1:0] != 2'b00) ? STB_AXI_SLVERR : STB_AXI_OKAY;
    end
    else if (RVALID && RREADY)
    begin
      RVALID <= 1'b0;
      ARREADY <= 1'b1;
    end
  end

  // Transmitter: a break or preamble is a bare run of zeros or ones
  assign load_now = (tx_state_r == TX_IDLE || (tx_cnt_r == 4'h1 && tx_div_r == 16'h0000))
                    && ctrl2_r[STB_C2_TX_EN];
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      tx_state_r <= TX_IDLE;
      load_kind_r <= LD_DATA;
      tx_shf_r <= 12'hFFF;
      tx_cnt_r <= 4'h0;
      tx_div_r <= 16'h0000;
      preamble_pend_r <= 1'b0;
      brk_tail_r <= 1'b0;
      tx_empty_r <= 1'b1;
      tx_en_prev_r <= 1'b0;
      TXD <= 1'b1;
    end
    else
    begin
      tx_en_prev_r <= ctrl2_r[STB_C2_TX_EN];
      if (ctrl2_r[STB_C2_TX_EN] && !tx_en_prev_r)
        preamble_pend_r <= 1'b1;
      if (data_wr)
        tx_empty_r <= 1'b0;
      if (tx_state_r == TX_SHIFT && !(tx_cnt_r == 4'h1 && tx_div_r == 16'h0000))
      begin
        // Keeps shifting even with enable low, so the frame completes
        if (tx_div_r != 16'h0000)
          tx_div_r <= tx_div_r - 16'h0001;
        else
        begin
          tx_div_r <= baud_r - 16'h0001;
          tx_cnt_r <= tx_cnt_r - 4'h1;
          tx_shf_r <= {1'b1, tx_shf_r[11:1]};
          TXD <= tx_shf_r[1];
        end
      end
      else if (load_now)
      begin
        tx_state_r <= TX_SHIFT;
        tx_div_r <= baud_r - 16'h0001;
        tx_cnt_r <= char_bits;
        if (preamble_pend_r || !tx_en_prev_r)
        begin
          preamble_pend_r <= 1'b0;
          load_kind_r <= LD_PREAMBLE;
          tx_shf_r <= 12'hFFF;
          TXD <= 1'b1;
        end
        else if (ctrl2_r[STB_C2_SEND_BRK])
        begin
          load_kind_r <= LD_BREAK;
          brk_tail_r <= 1'b1;
          tx_shf_r <= 12'h000;
          TXD <= 1'b0;
        end
        else if (brk_tail_r)
        begin
          brk_tail_r <= 1'b0;
          load_kind_r <= LD_PREAMBLE;
          tx_cnt_r <= 4'h1;
          tx_shf_r <= 12'hFFF;
          TXD <= 1'b1;
        end
        else if (!tx_empty_r && !data_wr)
        begin
          load_kind_r <= LD_DATA;
          tx_shf_r <= frame_word;
          tx_empty_r <= 1'b1;
          TXD <= frame_word[0];
        end
        else
        begin
          tx_state_r <= TX_IDLE;
          TXD <= 1'b1;
        end
      end
      else
      begin
        tx_state_r <= TX_IDLE;
        TXD <= 1'b1;
      end
    end
  end

  assign rif.enable = ctrl2_r[STB_C2_RX_EN];
  assign rif.long_char = ctrl1_r[STB_C1_LONG];
  assign rif.par_en = ctrl1_r[STB_C1_PAR_EN];
  assign rif.par_odd = ctrl1_r[STB_C1_PAR_ODD];
  assign rif.brk_det_en = ctrl1_r[STB_C1_BRK_DET_EN];
  assign rif.bit_div = baud_r;

  stb_rx u_rx
  (
    .clk(CLK),
    .rst(SYS_RST),
    .rxd(rx_sync_r[1]),
    .rif(rif)
  );

  always_comb
  begin
    stat_set = '0;
    stat_set[STB_ST_BRK_IRQ] = rif.brk_seen;
    stat_set[STB_ST_NOISE] = rif.noise;
    if (rif.rx_done)
    begin
      stat_set[STB_ST_RX_FULL] = 1'b1;
      stat_set[STB_ST_OVERRUN] = stat_r[STB_ST_RX_FULL];
      stat_set[STB_ST_FRAME_ERR] = rif.frame_err;
      stat_set[STB_ST_PAR_ERR] = rif.par_err;
    end
  end

  // Sticky status: a set in the clearing read's cycle wins
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      stat_r <= '0;
      rdr_r <= 9'h000;
    end
    else
    begin
      stat_r <= (stat_rd ? '0 : stat_r) | stat_set;
      stat_r[STB_ST_TX_EMPTY] <= tx_empty_r;
      stat_r[STB_ST_TX_DONE] <= tx_state_r == TX_IDLE && tx_empty_r;
      stat_r[STB_ST_RX_ACTIVE] <= rif.active;
      if (data_rd && !rif.rx_done)
        stat_r[STB_ST_RX_FULL] <= 1'b0;
      // A break with detect off clears the data even over an unread byte
      if (rif.rx_done && (!stat_r[STB_ST_RX_FULL]
          || (rif.frame_err && rif.rx_data == 9'h000)))
        rdr_r <= rif.rx_data;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      IRQ <= 1'b0;
    else
      IRQ <= |(stat_r & mask_r);
  end
endmodule

//--- tb/stb_props.sv
// Port-level checker for the serial transmit/break block.
// Assumes one clock domain with an async active-high reset; bound to the top.
`timescale 1ns/1ps
module stb_props
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0] RRESP,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic RXD,
  input wire logic TXD,
  input wire logic IRQ
);
  import stb_pkg::*;
  default clocking dcb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  logic [7:0] aw_addr_r;
  logic refuse_w;
  // Latched so a response is judged against the address that caused it
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      aw_addr_r <= 8'h00;
    else if (AWVALID && AWREADY)
      aw_addr_r <= AWADDR;
  end
  assign refuse_w = (aw_addr_r[1:0] != 2'h0) || (aw_addr_r > STB_OFS_MASK)
    || (aw_addr_r == STB_OFS_STAT);
  write_answer_a: assert property (AWVALID && AWREADY && WVALID && WREADY |=> ##1 BVALID)
    else $error("write response missing");
  read_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read response missing");
  bresp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped early");
  rdata_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped early");
  write_block_a: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while response pending");
  read_block_a: assert property (RVALID |-> !ARREADY)
    else $error("read taken while response pending");
  bad_write_a: assert property (BVALID && refuse_w |-> BRESP == STB_AXI_SLVERR)
    else $error("refused write not flagged");
  good_write_a: assert property (BVALID && !refuse_w |-> BRESP == STB_AXI_OKAY)
    else $error("legal write flagged");
  low_bit_a: assert property ($fell(TXD) |=> !TXD)
    else $error("transmit low shorter than a bit");
  high_bit_a: assert property ($rose(TXD) |=> TXD)
    else $error("transmit high shorter than a bit");
  cover property (BVALID && BREADY && BRESP == STB_AXI_SLVERR);
  cover property ($fell(TXD));
  cover property ($rose(IRQ));
endmodule

bind stb_top stb_props u_props
(
  .CLK(CLK), .SYS_RST(SYS_RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
  .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
  .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
  .RXD(RXD), .TXD(TXD), .IRQ(IRQ)
);

//--- tb/stb_remote.sv
// Remote transceiver model: drives the receive line and decodes the transmit line.
// Assumes its bit time in clocks equals the divider the bench programs.
`timescale 1ns/1ps
module stb_remote
#(
  parameter int BT = 8
)
(
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  logic [8:0] rxq[$];
  int gap[$];
  int zrun = 0;
  int zmax = 0;
  int orun = 0;
  logic [8:0] f;
  initial rxd = 1'h1;
  // Run lengths in clocks; the longest low run exposes break length
  always @(posedge clk)
  begin
    zrun = txd ? 0 : zrun + 1;
    orun = txd ? orun + 1 : 0;
    if (zrun > zmax)
      zmax = zrun;
  end
  // Mid-bit sampling; a break shows as zero data with a low stop bit
  initial forever
  begin
    @(negedge txd);
    gap.push_back(orun);
    repeat (BT / 2) @(posedge clk);
    for (int i = 0; i < 9; i++)
    begin
      repeat (BT) @(posedge clk);
      f[i] = txd;
    end
    rxq.push_back(f);
  end
  task automatic send(input logic [15:0] b, input int n);
    for (int i = 0; i < n; i++)
    begin
      rxd <= b[i];
      repeat (BT) @(posedge clk);
    end
    rxd <= 1'h1;
    repeat (2 * BT) @(posedge clk);
  endtask
endmodule

//--- tb/serial_tx_break_handler_test.sv
// Self-checking bench: AXI4-Lite register tasks plus the remote line model.
// Assumes the hand-over timing of the top and a bit time of BT clocks.
`timescale 1ns/1ps
module serial_tx_break_handler_test;
  import stb_pkg::*;
  localparam int BT = 8;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, irq, txd, rxd;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, s;
  int error_cnt = 0;
  int samples_checked = 0;
  always #5 clk = ~clk;
  stb_top dut (.CLK(clk), .SYS_RST(sys_rst), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .RXD(rxd), .TXD(txd), .IRQ(irq));
  stb_remote #(.BT(BT)) rem (.clk(clk), .txd(txd), .rxd(rxd));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // The trailing edge keeps a strobe from being dropped and raised in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
    end
    while (bvalid !== 1'h1);
    r = bresp;
    bready <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'h0;
    end
    while (rvalid !== 1'h1);
    s = rdata;
    r = rresp;
    rready <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wait_empty();
    do
      rd(STB_OFS_STAT);
    while (s[STB_ST_TX_EMPTY] !== 1'h1);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    rd(STB_OFS_BAUD);
    chk(s, 32'h10);
    chk({30'h0, r}, {30'h0, STB_AXI_OKAY});
    wr(8'h18, 32'h1);
    chk({30'h0, r}, {30'h0, STB_AXI_SLVERR});
    rd(8'h18);
    chk(s, 32'h0);
    chk({30'h0, r}, {30'h0, STB_AXI_SLVERR});
    wr(STB_OFS_STAT, 32'h0);
    chk({30'h0, r}, {30'h0, STB_AXI_SLVERR});
    wr(STB_OFS_BAUD, 32'(BT));
    $display("register test done");
    wr(STB_OFS_CTRL2, 32'h3);
    wr(STB_OFS_DATA, 32'h5A);
    wait_empty();
    wr(STB_OFS_CTRL2, 32'h1);
    wr(STB_OFS_CTRL2, 32'h3);
    wr(STB_OFS_DATA, 32'hC3);
    wait_empty();
    wr(STB_OFS_CTRL2, 32'h1);
    repeat (25 * BT) @(posedge clk);
    chk({23'h0, rem.rxq[0]}, 32'h15A);
    chk({23'h0, rem.rxq[1]}, 32'h1C3);
    chk(32'(rem.gap[1] >= 10 * BT), 32'h1);
    chk({31'h0, txd}, 32'h1);
    wr(STB_OFS_CTRL2, 32'h3);
    repeat (12 * BT) @(posedge clk);
    for (int l = 0; l < 2; l++)
    begin
      wr(STB_OFS_CTRL1, 32'(l));
      rem.zmax = 0;
      wr(STB_OFS_CTRL2, 32'h7);
      wr(STB_OFS_DATA, 32'h0);
      wr(STB_OFS_CTRL2, 32'h3);
      repeat (40 * BT) @(posedge clk);
      chk(32'(rem.zmax), 32'((10 + l) * BT));
    end
    rem.zmax = 0;
    wr(STB_OFS_CTRL2, 32'h7);
    repeat (25 * BT) @(posedge clk);
    wr(STB_OFS_CTRL2, 32'h1);
    repeat (15 * BT) @(posedge clk);
    chk(32'(rem.zmax >= 22 * BT), 32'h1);
    chk({31'h0, txd}, 32'h1);
    wr(STB_OFS_CTRL1, 32'h0);
    $display("transmit test done");
    wr(STB_OFS_MASK, 32'h20);
    rd(STB_OFS_STAT);
    rem.send(16'h02B4, 10);
    rem.send(16'h0000, 10);
    chk({31'h0, irq}, 32'h1);
    rd(STB_OFS_STAT);
    chk(s & 32'h24, 32'h24);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rd(STB_OFS_DATA);
    chk(s, 32'h0);
    wr(STB_OFS_CTRL1, 32'h8);
    wr(STB_OFS_MASK, 32'h80);
    rem.send(16'h02B4, 10);
    rd(STB_OFS_STAT);
    chk(s & 32'h4, 32'h4);
    rem.send(16'h0000, 10);
    chk({31'h0, irq}, 32'h1);
    rd(STB_OFS_STAT);
    chk(s & 32'hE8, 32'h80);
    rd(STB_OFS_DATA);
    chk(s, 32'h5A);
    rem.send(16'h000A, 14);
    rd(STB_OFS_STAT);
    chk(s & 32'hA4, 32'hA4);
    rd(STB_OFS_DATA);
    chk(s, 32'h5);
    rem.send(16'h0000, 9);
    rd(STB_OFS_STAT);
    chk(s & 32'hA4, 32'h4);
    wr(STB_OFS_CTRL1, 32'h2);
    rem.send(16'h0202, 10);
    rd(STB_OFS_STAT);
    chk(s & 32'h64, 32'h44);
    $display("receive test done");
    report_and_stop();
  end
  initial
  begin
    repeat (50000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
endmodule
